// >>> bench/eam_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module eam_mem_model (
   input wire logic ref_clk,
   input wire logic [17:0] ext_addr,
   input wire logic [23:0] ext_data_o,
   input wire logic ext_data_oe,
   input wire logic ext_rd_n,
   input wire logic ext_wr_n,
   input wire logic [3:0] attr_pins_all,
   input wire logic [3:0] ack_lag,
   output logic [23:0] ext_data_i,
   output logic transfer_ack_in_n
);
   // ****************************************************************
   // async memory, attribute pins used as extra address lines
   // ****************************************************************
   logic [23:0] mem [logic [21:0]];
   int cnt = 0;
   wire logic [21:0] key = {attr_pins_all, ext_addr};
   initial begin
      ext_data_i = 24'h0000_00;
      transfer_ack_in_n = 1'b1;
   end
   always @(posedge ref_clk) begin
      if (!ext_wr_n && ext_data_oe) mem[key] = ext_data_o;
      cnt <= (ext_rd_n && ext_wr_n) ? 0 : cnt + 1;
   end
   // released data bus toggles so no stale value is seen
   always @(negedge ref_clk) begin
      transfer_ack_in_n <= !((!ext_rd_n || !ext_wr_n) && cnt >= ack_lag);
      if (!ext_rd_n) ext_data_i <= mem.exists(key) ? mem[key] : {2'b10, key};
      else ext_data_i <= ~ext_data_i;
   end
endmodule // eam_mem_model
`default_nettype wire

// >>> bench/eam_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "eam_regs.vh"
module eam_port_properties (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [23:0] io_addr,
   input wire logic io_wr,
   input wire logic [23:0] io_wdata,
   input wire logic acc_done,
   input wire logic ext_data_oe,
   input wire logic ext_rd_n,
   input wire logic ext_wr_n,
   input wire logic [3:0] attr_pins_all,
   input wire logic bus_busy_pin_o,
   input wire logic bus_busy_pin_oe,
   input wire logic [3:0] boot_mode_select,
   input wire logic mem_switch_mode
);
   // ****************************************************************
   // port checks
   // ****************************************************************
   logic [23:0] wdata_r;
   logic [23:0] wdata_q;
   always @(posedge ref_clk) begin
      wdata_r <= io_wdata;
      wdata_q <= wdata_r;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_strobe_on;
      !ext_rd_n || !ext_wr_n;
   endsequence
   sequence s_rd_start;
      $fell(ext_rd_n);
   endsequence
   sequence s_rd_held;
      !ext_rd_n && $past(ext_rd_n) == 1'b0;
   endsequence
   a_done_release: assert property (acc_done |-> ext_rd_n && ext_wr_n)
      else $error("strobe low at done");
   a_strobe_excl: assert property (ext_rd_n || ext_wr_n)
      else $error("both strobes low");
   a_wr_drives: assert property (!ext_wr_n |-> ext_data_oe)
      else $error("write without data drive");
   a_rd_floats: assert property (!ext_rd_n |-> !ext_data_oe)
      else $error("read while driving data");
   a_done_min: assert property (s_rd_start |-> !acc_done [*3])
      else $error("access shorter than sync delay");
   a_pins_hold: assert property (s_rd_held |-> $stable(attr_pins_all))
      else $error("attribute pins moved mid access");
   a_busy_during: assert property (s_strobe_on |-> bus_busy_pin_oe)
      else $error("bus busy not held");
   a_busy_level: assert property (bus_busy_pin_oe |-> !bus_busy_pin_o)
      else $error("bus busy driven high");
   a_mode_copy: assert property (io_wr && io_addr == `EAM_OFS_MODE |-> ##2
      boot_mode_select == wdata_q[3:0] && mem_switch_mode == wdata_q[7])
      else $error("mode copy wrong");
endmodule // eam_port_properties
bind eam_port eam_port_properties u_props (.ref_clk(ref_clk), .rstn(rstn), .io_addr(io_addr),
   .io_wr(io_wr), .io_wdata(io_wdata), .acc_done(acc_done), .ext_data_oe(ext_data_oe),
   .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .attr_pins_all(attr_pins_all),
   .bus_busy_pin_o(bus_busy_pin_o), .bus_busy_pin_oe(bus_busy_pin_oe),
   .boot_mode_select(boot_mode_select), .mem_switch_mode(mem_switch_mode));
`default_nettype wire

// >>> bench/tb_external_memory_attribute_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "eam_regs.vh"
module tb_external_memory_attribute_port;
   logic ref_clk = 0, rstn = 0, io_wr = 0, io_rd = 0, acc_req = 0, acc_write = 0;
   logic [23:0] io_addr = 0, io_wdata = 0, acc_addr = 0, acc_wdata = 0, d;
   logic [1:0] acc_space = 0;
   logic acc_dma = 0;
   logic [3:0] ack_lag = 0, s_pins;
   logic [17:0] s_ea;
   logic s_strobe, s_bb;
   wire logic [23:0] io_rdata, acc_rdata, ext_data_i, ext_data_o;
   wire logic [17:0] ext_addr;
   wire logic [3:0] pins, boot_mode_select;
   wire logic acc_done, ext_data_oe, ext_rd_n, ext_wr_n, ack_n, bb_o, bb_oe, msw;
   int fail_count = 0, total_checks = 0, n;
   eam_port uut (.ref_clk(ref_clk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr),
      .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .acc_req(acc_req),
      .acc_addr(acc_addr), .acc_space(acc_space), .acc_write(acc_write), .acc_dma(acc_dma),
      .acc_wdata(acc_wdata), .acc_done(acc_done), .acc_rdata(acc_rdata), .ext_addr(ext_addr),
      .ext_data_i(ext_data_i), .ext_data_o(ext_data_o), .ext_data_oe(ext_data_oe),
      .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .attr_pins_all(pins),
      .transfer_ack_in_n(ack_n), .bus_busy_pin_o(bb_o), .bus_busy_pin_oe(bb_oe),
      .boot_mode_select(boot_mode_select), .mem_switch_mode(msw));
   eam_mem_model mem (.ref_clk(ref_clk), .ext_addr(ext_addr), .ext_data_o(ext_data_o),
      .ext_data_oe(ext_data_oe), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
      .attr_pins_all(pins), .ack_lag(ack_lag), .ext_data_i(ext_data_i),
      .transfer_ack_in_n(ack_n));
   initial forever #25 ref_clk = ~ref_clk;
   // ****************************************************************
   // bus tasks
   // ****************************************************************
   task automatic stop_test;
      if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [23:0] a, input logic [23:0] v);
      @(negedge ref_clk);
      io_addr = a;
      io_wdata = v;
      io_wr = 1;
      @(negedge ref_clk);
      io_wr = 0;
   endtask
   task automatic rd(input logic [23:0] a);
      @(negedge ref_clk);
      io_addr = a;
      io_rd = 1;
      @(negedge ref_clk);
      io_rd = 0;
      d = io_rdata;
   endtask
   task automatic acc(input logic [23:0] a, input logic [1:0] sp, input logic w);
      @(negedge ref_clk);
      acc_addr = a;
      acc_space = sp;
      acc_write = w;
      acc_wdata = 24'hc35a_96;
      acc_req = 1;
      n = 1;
      s_strobe = 0;
      @(negedge ref_clk);
      acc_req = 0;
      while (acc_done !== 1'b1 && n < 300) begin
         if (!ext_rd_n || !ext_wr_n) begin
            s_strobe = 1;
            s_pins = pins;
            s_ea = ext_addr;
         end
         @(negedge ref_clk);
         n++;
      end
      chk("acc done", 1'b1, acc_done);
      s_bb = bb_oe;
      repeat (2) @(negedge ref_clk);
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regs;
      logic [23:0] ofs [6];
      ofs = '{`EAM_OFS_AREA0, `EAM_OFS_AREA1, `EAM_OFS_AREA2, `EAM_OFS_AREA3,
         `EAM_OFS_BUSCTL, `EAM_OFS_MODE};
      chk("reset pins", 4'hf, pins);
      for (int i = 0; i < 6; i++) wr(ofs[i], 24'hffff_ff);
      for (int i = 0; i < 6; i++) begin
         rd(ofs[i]);
         chk("reg readback", (i == 4) ? 24'hdfff_ff : 24'hffff_ff, d);
      end
      rd(24'hffff_fa);
      chk("unmapped read", 24'h0000_00, d);
      wr(`EAM_OFS_MODE, 24'h0040_8b);
      @(negedge ref_clk);
      chk("boot mode", 4'hb, boot_mode_select);
      chk("mem switch", 1'b1, msw);
      chk("hold busy", 1'b1, bb_oe);
   endtask
   task automatic t_areas;
      logic [23:0] ad [6] = '{24'h1001_23, 24'h1001_23, 24'h1001_23, 24'h2000_40,
         24'h3001_a5, 24'h4000_77};
      logic [1:0] sp [6] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h0, 2'h1};
      logic [3:0] pn [6] = '{4'h1, 4'h2, 4'h0, 4'h4, 4'h8, 4'h0};
      // cycles: the longer of wait count and two-flop ack delay, plus two
      int ws [6] = '{4, -1, -1, 7, 9, 5};
      logic [17:0] ea;
      wr(`EAM_OFS_AREA0, 24'h1007_15);
      wr(`EAM_OFS_AREA1, 24'h1007_0d);
      wr(`EAM_OFS_AREA2, 24'h2007_3d);
      wr(`EAM_OFS_AREA3, 24'h3007_7d);
      wr(`EAM_OFS_BUSCTL, 24'h03f4_22);
      wr(`EAM_OFS_MODE, 24'h0040_00);
      for (int i = 0; i < 6; i++) begin
         ea = (i == 4) ? 18'h2_9401 : ad[i][17:0];
         acc(ad[i], sp[i], 1'b0);
         chk("pins", pn[i], s_pins);
         chk("ext addr", ea, s_ea);
         chk("read data", {2'b10, pn[i], ea}, acc_rdata);
         if (ws[i] >= 0) chk("cycles", ws[i], n);
      end
      wr(`EAM_OFS_AREA3, 24'h3007_7c);
      acc(24'h3001_a5, 2'h0, 1'b0);
      chk("type off pins", 4'h0, s_pins);
      chk("type off addr", 18'h0_01a5, s_ea);
   endtask
   task automatic t_modes;
      logic [23:0] md [4] = '{24'h0040_00, 24'h0048_00, 24'h0050_00, 24'h0000_00};
      int cy [4] = '{4, 5, 4, 4};
      wr(`EAM_OFS_AREA1, 24'h1007_1d);
      for (int i = 0; i < 4; i++) begin
         wr(`EAM_OFS_MODE, md[i]);
         acc(24'h1001_23, 2'h1, 1'b0);
         chk("sync cycles", cy[i], n);
         chk("busy at done", i == 2, s_bb);
         chk("prio pins", (i == 3) ? 4'h1 : 4'h3, s_pins);
      end
   endtask
   task automatic t_data;
      wr(`EAM_OFS_MODE, 24'h0040_00);
      ack_lag = 4;
      acc(24'h1002_00, 2'h1, 1'b1);
      acc(24'h1002_00, 2'h1, 1'b0);
      ack_lag = 0;
      chk("written data", 24'hc35a_96, acc_rdata);
      // packed dma word: three bytes on the low lane, byte index on the low lines
      acc_dma = 1;
      wr(`EAM_OFS_AREA0, 24'h1007_95);
      acc(24'h1002_40, 2'h1, 1'b1);
      chk("pack addr", 18'h0_0902, s_ea);
      acc(24'h1002_40, 2'h1, 1'b0);
      chk("packed data", 24'hc35a_96, acc_rdata);
      acc_dma = 0;
      acc(24'h1009_00, 2'h1, 1'b0);
      chk("byte lane", 24'h0000_96, acc_rdata);
      wr(`EAM_OFS_AREA0, 24'h1007_15);
      wr(`EAM_OFS_MODE, 24'h0040_10);
      acc(24'h1001_23, 2'h1, 1'b0);
      chk("off cycles", 1, n);
      chk("off strobes", 1'b0, s_strobe);
      chk("off data", 24'h0000_00, acc_rdata);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      @(negedge ref_clk);
      rstn = 1;
      t_regs;
      t_areas;
      t_modes;
      t_data;
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      stop_test;
   end
endmodule // tb_external_memory_attribute_port
`default_nettype wire

// >>> src/eam_port.v
`timescale 1ns/1ps
`default_nettype none
`include "eam_regs.vh"
module eam_port (
   input wire ref_clk,
   input wire rstn,
   input wire [23:0] io_addr,
   input wire io_wr,
   input wire io_rd,
   input wire [23:0] io_wdata,
   output reg [23:0] io_rdata,
   input wire acc_req,
   input wire [23:0] acc_addr,
   input wire [1:0] acc_space,
   input wire acc_write,
   input wire acc_dma,
   input wire [23:0] acc_wdata,
   output reg acc_done,
   output reg [23:0] acc_rdata,
   output reg [17:0] ext_addr,
   input wire [23:0] ext_data_i,
   output reg [23:0] ext_data_o,
   output reg ext_data_oe,
   output reg ext_rd_n,
   output reg ext_wr_n,
   output reg [3:0] attr_pins_all,
   input wire transfer_ack_in_n,
   output reg bus_busy_pin_o,
   output reg bus_busy_pin_oe,
   output reg [3:0] boot_mode_select,
   output reg mem_switch_mode
);
   // ****************************************************************
   // state and registers
   // ****************************************************************
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_WAIT = 3'h1;
   localparam [2:0] ST_GAP = 3'h2;
   localparam [2:0] ST_REL = 3'h3;
   reg [23:0] area_r [0:3];
   reg [23:0] busctl_r;
   reg [23:0] mode_r;
   reg [2:0] st_r;
   reg [4:0] cnt_r;
   reg [4:0] ws_r;
   reg [1:0] byte_r;
   reg pack_r;
   reg swap_r;
   reg write_r;
   reg [23:0] addr_r;
   reg [23:0] wdata_r;
   reg [23:0] rdata_r;
   reg ta_s1_r;
   reg ta_s2_r;
   reg ta_s3_r;
   wire [3:0] hit;
   wire [3:0] pin_on;
   reg [3:0] win;
   reg [4:0] ws_sel;
   reg pack_sel;
   reg swap_sel;
   reg [3:0] pins_nxt;
   reg [17:0] addr_nxt;
   wire [17:0] cur_addr;
   wire ta_ok;
   wire bus_hold;
   reg [23:0] src_addr;
   reg [1:0] src_byte;
   reg src_pack;
   reg src_swap;
   integer i;
   integer j;
   // ****************************************************************
   // area match and pin qualification
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_area
         wire [23:0] cfg = area_r[g];
         wire [3:0] nb = cfg[`EAM_AT_NBITS_HI:`EAM_AT_NBITS_LO];
         wire [11:0] base = cfg[`EAM_AT_BASE_HI:`EAM_AT_BASE_LO];
         wire [11:0] diff = base ^ acc_addr[23:12];
         reg [11:0] mask;
         integer k;
         always @* begin
            mask = 12'h000;
            for (k = 0; k < 12; k = k + 1) begin
               if (k < nb) begin
                  mask[11 - k] = 1'b1;
               end
            end
         end
         assign hit[g] = (cfg[`EAM_AT_TYPE_HI:`EAM_AT_TYPE_LO] == `EAM_AT_TYPE_ASYNC) &&
            ((diff & mask) == 12'h000);
         assign pin_on[g] = hit[g] &&
            ((acc_space == `EAM_SPACE_P && cfg[`EAM_AT_EN_P]) ||
            (acc_space == `EAM_SPACE_X && cfg[`EAM_AT_EN_X]) ||
            (acc_space == `EAM_SPACE_Y && cfg[`EAM_AT_EN_Y]));
      end
   endgenerate
   // ****************************************************************
   // priority, wait states and pin levels for a new access
   // ****************************************************************
   always @* begin
      win = 4'h0;
      if (mode_r[`EAM_OM_PRIDIS]) begin
         win = pin_on;
      end else if (hit[0]) begin
         win = {3'h0, pin_on[0]};
      end else if (hit[1]) begin
         win = {2'h0, pin_on[1], 1'b0};
      end else if (hit[2]) begin
         win = {1'b0, pin_on[2], 2'h0};
      end else if (hit[3]) begin
         win = {pin_on[3], 3'h0};
      end
      ws_sel = busctl_r[`EAM_BC_WSD_HI:`EAM_BC_WSD_LO];
      pack_sel = 1'b0;
      swap_sel = 1'b0;
      for (i = 3; i >= 0; i = i - 1) begin
         if (hit[i]) begin
            pack_sel = area_r[i][`EAM_AT_PACK] & acc_dma;
            swap_sel = area_r[i][`EAM_AT_SWAP];
         end
      end
      if (hit[0]) begin
         ws_sel = busctl_r[`EAM_BC_WS0_HI:`EAM_BC_WS0_LO];
      end else if (hit[1]) begin
         ws_sel = busctl_r[`EAM_BC_WS1_HI:`EAM_BC_WS1_LO];
      end else if (hit[2]) begin
         ws_sel = {2'h0, busctl_r[`EAM_BC_WS2_HI:`EAM_BC_WS2_LO]};
      end else if (hit[3]) begin
         ws_sel = {2'h0, busctl_r[`EAM_BC_WS3_HI:`EAM_BC_WS3_LO]};
      end
      for (i = 0; i < 4; i = i + 1) begin
         pins_nxt[i] = area_r[i][`EAM_AT_POL] ? win[i] : ~win[i];
      end
   end
   // ****************************************************************
   // external address path
   // ****************************************************************
   // the address must leave with the strobe edge: a new request and the
   // next packed byte are steered in ahead of their registers
   always @* begin
      src_addr = addr_r;
      src_pack = pack_r;
      src_swap = swap_r;
      src_byte = byte_r;
      if (st_r == ST_IDLE && acc_req && !mode_r[`EAM_OM_EXTDIS]) begin
         src_addr = acc_addr;
         src_pack = pack_sel;
         src_swap = swap_sel;
         src_byte = 2'h0;
      end else if (st_r == ST_GAP) begin
         src_byte = byte_r + 2'h1;
      end
   end
   // upper internal bits never reach the bus; packed bytes index the low lines
   assign cur_addr = src_pack ? {src_addr[15:0], src_byte} : src_addr[17:0];
   always @* begin
      if (src_swap) begin
         addr_nxt = {cur_addr[7:0], cur_addr[17:8]};
      end else begin
         addr_nxt = cur_addr;
      end
   end
   // ****************************************************************
   // acknowledge synchroniser
   // ****************************************************************
   assign ta_ok = mode_r[`EAM_OM_TASYNC] ? ~ta_s3_r : ~ta_s2_r;
   assign bus_hold = busctl_r[`EAM_BC_LOCKH] | busctl_r[`EAM_BC_REQH];
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ta_s1_r <= 1'b1;
         ta_s2_r <= 1'b1;
         ta_s3_r <= 1'b1;
      end else begin
         ta_s1_r <= transfer_ack_in_n;
         ta_s2_r <= ta_s1_r;
         ta_s3_r <= ta_s2_r;
      end
   end
   // ****************************************************************
   // register file
   // ****************************************************************
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (j = 0; j < 4; j = j + 1) begin
            area_r[j] <= `EAM_RST_REG;
         end
         busctl_r <= `EAM_RST_REG;
         mode_r <= `EAM_RST_REG;
         io_rdata <= 24'h00_0000;
         boot_mode_select <= 4'h0;
         mem_switch_mode <= 1'b0;
      end else begin
         if (io_wr) begin
            case (io_addr)
               `EAM_OFS_AREA0: area_r[0] <= io_wdata;
               `EAM_OFS_AREA1: area_r[1] <= io_wdata;
               `EAM_OFS_AREA2: area_r[2] <= io_wdata;
               `EAM_OFS_AREA3: area_r[3] <= io_wdata;
               `EAM_OFS_BUSCTL: busctl_r <= {io_wdata[23:22], 1'b0, io_wdata[20:0]};
               `EAM_OFS_MODE: mode_r <= io_wdata;
               default: ;
            endcase
         end
         busctl_r[`EAM_BC_BSTAT] <= (st_r != ST_IDLE);
         boot_mode_select <= mode_r[`EAM_OM_MODE_HI:`EAM_OM_MODE_LO];
         mem_switch_mode <= mode_r[`EAM_OM_MSWITCH];
         if (io_rd) begin
            case (io_addr)
               `EAM_OFS_AREA0: io_rdata <= area_r[0];
               `EAM_OFS_AREA1: io_rdata <= area_r[1];
               `EAM_OFS_AREA2: io_rdata <= area_r[2];
               `EAM_OFS_AREA3: io_rdata <= area_r[3];
               `EAM_OFS_BUSCTL: io_rdata <= busctl_r;
               `EAM_OFS_MODE: io_rdata <= mode_r;
               default: io_rdata <= 24'h00_0000;
            endcase
         end
      end
   end
   // ****************************************************************
   // external access sequencer
   // ****************************************************************
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= ST_IDLE;
         cnt_r <= 5'h00;
         ws_r <= 5'h00;
         byte_r <= 2'h0;
         pack_r <= 1'b0;
         swap_r <= 1'b0;
         write_r <= 1'b0;
         addr_r <= 24'h00_0000;
         wdata_r <= 24'h00_0000;
         rdata_r <= 24'h00_0000;
         acc_done <= 1'b0;
         acc_rdata <= 24'h00_0000;
         ext_addr <= 18'h0_0000;
         ext_data_o <= 24'h00_0000;
         ext_data_oe <= 1'b0;
         ext_rd_n <= 1'b1;
         ext_wr_n <= 1'b1;
         attr_pins_all <= 4'hf;
         bus_busy_pin_o <= 1'b0;
         bus_busy_pin_oe <= 1'b0;
      end else begin
         acc_done <= 1'b0;
         ext_addr <= addr_nxt;
         case (st_r)
            ST_IDLE: begin
               bus_busy_pin_oe <= bus_hold;
               if (acc_req) begin
                  if (mode_r[`EAM_OM_EXTDIS]) begin
                     acc_done <= 1'b1;
                     acc_rdata <= 24'h00_0000;
                  end else begin
                     addr_r <= acc_addr;
                     wdata_r <= acc_wdata;
                     write_r <= acc_write;
                     pack_r <= pack_sel;
                     swap_r <= swap_sel;
                     byte_r <= 2'h0;
                     rdata_r <= 24'h00_0000;
                     ws_r <= ws_sel;
                     cnt_r <= ws_sel;
                     attr_pins_all <= pins_nxt;
                     ext_rd_n <= acc_write;
                     ext_wr_n <= ~acc_write;
                     ext_data_oe <= acc_write;
                     ext_data_o <= pack_sel ? {16'h0000, acc_wdata[7:0]} : acc_wdata;
                     bus_busy_pin_oe <= 1'b1;
                     st_r <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               if (cnt_r != 5'h00) begin
                  cnt_r <= cnt_r - 5'h01;
               end else if (ta_ok) begin
                  ext_rd_n <= 1'b1;
                  ext_wr_n <= 1'b1;
                  if (pack_r) begin
                     rdata_r <= {ext_data_i[7:0], rdata_r[23:8]};
                  end
                  if (pack_r && byte_r != `EAM_PACK_LAST) begin
                     st_r <= ST_GAP;
                  end else begin
                     acc_done <= 1'b1;
                     acc_rdata <= pack_r ? {ext_data_i[7:0], rdata_r[23:8]} : ext_data_i;
                     attr_pins_all <= 4'hf ^ {area_r[3][`EAM_AT_POL], area_r[2][`EAM_AT_POL],
                        area_r[1][`EAM_AT_POL], area_r[0][`EAM_AT_POL]};
                     ext_data_oe <= 1'b0;
                     if (mode_r[`EAM_OM_SLOWREL]) begin
                        st_r <= ST_REL;
                     end else begin
                        bus_busy_pin_oe <= bus_hold;
                        st_r <= ST_IDLE;
                     end
                  end
               end
            end
            ST_GAP: begin
               byte_r <= byte_r + 2'h1;
               cnt_r <= ws_r;
               ext_rd_n <= write_r;
               ext_wr_n <= ~write_r;
               ext_data_o <= {16'h0000, (byte_r == 2'h0) ? wdata_r[15:8] : wdata_r[23:16]};
               st_r <= ST_WAIT;
            end
            ST_REL: begin
               bus_busy_pin_oe <= bus_hold;
               st_r <= ST_IDLE;
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end
endmodule // eam_port
`default_nettype wire

// >>> src/eam_regs.vh
`ifndef EAM_REGS_VH
`define EAM_REGS_VH
// ****************************************************************
// register offsets in the peripheral i/o space
// ****************************************************************
`define EAM_OFS_AREA0 24'hff_fff9
`define EAM_OFS_AREA1 24'hff_fff8
`define EAM_OFS_AREA2 24'hff_fff7
`define EAM_OFS_AREA3 24'hff_fff6
`define EAM_OFS_BUSCTL 24'hff_fffb
`define EAM_OFS_MODE 24'hff_fff5
// ****************************************************************
// attribute area fields
// ****************************************************************
`define EAM_AT_TYPE_LO 0
`define EAM_AT_TYPE_HI 1
`define EAM_AT_TYPE_ASYNC 2'h1
`define EAM_AT_POL 2
`define EAM_AT_EN_P 3
`define EAM_AT_EN_X 4
`define EAM_AT_EN_Y 5
`define EAM_AT_SWAP 6
`define EAM_AT_PACK 7
`define EAM_AT_NBITS_LO 8
`define EAM_AT_NBITS_HI 11
`define EAM_AT_BASE_LO 12
`define EAM_AT_BASE_HI 23
`define EAM_AT_BASE_W 12
// ****************************************************************
// bus control fields
// ****************************************************************
`define EAM_BC_WS0_LO 0
`define EAM_BC_WS0_HI 4
`define EAM_BC_WS1_LO 5
`define EAM_BC_WS1_HI 9
`define EAM_BC_WS2_LO 10
`define EAM_BC_WS2_HI 12
`define EAM_BC_WS3_LO 13
`define EAM_BC_WS3_HI 15
`define EAM_BC_WSD_LO 16
`define EAM_BC_WSD_HI 20
`define EAM_BC_BSTAT 21
`define EAM_BC_LOCKH 22
`define EAM_BC_REQH 23
// ****************************************************************
// operating mode fields
// ****************************************************************
`define EAM_OM_MODE_LO 0
`define EAM_OM_MODE_HI 3
`define EAM_OM_EXTDIS 4
`define EAM_OM_MSWITCH 7
`define EAM_OM_TASYNC 11
`define EAM_OM_SLOWREL 12
`define EAM_OM_PRIDIS 14
// ****************************************************************
// encodings and reset values
// ****************************************************************
`define EAM_SPACE_P 2'h0
`define EAM_SPACE_X 2'h1
`define EAM_SPACE_Y 2'h2
`define EAM_RST_REG 24'h00_0000
`define EAM_EXT_AW 18
`define EAM_PACK_LAST 2'h2
`endif
